//--- bench/hiac_mem_model.sv
`timescale 1ns/1ps

module hiac_mem_model
    import hiac_pkg::*;
(
    // Clock and stall control
    input wire logic clk_i,
    input wire logic stall_i,
    // Request side
    input wire logic valid_i,
    output logic ready_o,
    input wire hiac_mem_req_t req_i,
    // Read return
    output logic rvalid_o,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [logic [27:0]];
    logic [27:0] rq [$];
    logic [27:0] a;
    int wait_n = 0;
    int reqs = 0;
    hiac_mem_req_t last;
    initial begin
        ready_o = 1'b0;
        rvalid_o = 1'b0;
        rdata_o = 16'hFFFF;
        forever begin
            @(posedge clk_i);
            if (valid_i === 1'b1 && ready_o) begin
                reqs++;
                last = req_i;
                if (req_i.we) mem[req_i.addr[31:4]] = req_i.wdata;
                else rq.push_back(req_i.addr[31:4]);
            end
            #1;
            // Return data drops to its inverse once released
            if (rvalid_o) begin
                rvalid_o = 1'b0;
                rdata_o = ~rdata_o;
            end else if (wait_n > 0) begin
                wait_n--;
            end else if (rq.size() > 0) begin
                a = rq.pop_front();
                rdata_o = mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5A3C;
                rvalid_o = 1'b1;
                wait_n = $urandom_range(3, 0);
            end
            ready_o = !stall_i && ($urandom_range(3, 0) != 0);
        end
    end
endmodule : hiac_mem_model

//--- bench/host_indirect_access_control_bench.sv
`timescale 1ns/1ps

module host_indirect_access_control_bench;
    import hiac_pkg::*;
    logic CLK_I, RSTN_I, HOST_CS_I, HOST_RD_N_I, HOST_WR_N_I, CPU_SEL_I, CPU_WE_I;
    logic NMI_TAKEN_I, CACHE_DISABLE_I, MEM_REQ_READY_I, MEM_RVALID_I, stall;
    logic [1:0] HOST_SEL_I, HOST_BEN_N_I;
    logic [15:0] HOST_DATA_I, HOST_DATA_O, CPU_WDATA_I, CPU_RDATA_O, MEM_RDATA_I;
    logic [31:0] CPU_ADDR_I, a;
    logic HOST_DATA_OE_O, HOST_RDY_O, NMI_REQ_O, NMI_MODE_O, HALT_O;
    logic CACHE_FLUSH_O, CACHE_RESTART_O, MEM_REQ_VALID_O;
    hiac_mem_req_t MEM_REQ_O;
    logic [15:0] rd, hi, lo, d;
    int bad_count = 0, num_checks = 0, pulses = 0, n, r0;

    hiac_top uut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .HOST_CS_I(HOST_CS_I),
        .HOST_RD_N_I(HOST_RD_N_I), .HOST_WR_N_I(HOST_WR_N_I), .HOST_SEL_I(HOST_SEL_I),
        .HOST_BEN_N_I(HOST_BEN_N_I), .HOST_DATA_I(HOST_DATA_I), .HOST_DATA_O(HOST_DATA_O),
        .HOST_DATA_OE_O(HOST_DATA_OE_O), .HOST_RDY_O(HOST_RDY_O), .CPU_SEL_I(CPU_SEL_I),
        .CPU_WE_I(CPU_WE_I), .CPU_ADDR_I(CPU_ADDR_I), .CPU_WDATA_I(CPU_WDATA_I),
        .CPU_RDATA_O(CPU_RDATA_O), .NMI_TAKEN_I(NMI_TAKEN_I),
        .CACHE_DISABLE_I(CACHE_DISABLE_I), .NMI_REQ_O(NMI_REQ_O), .NMI_MODE_O(NMI_MODE_O),
        .HALT_O(HALT_O), .CACHE_FLUSH_O(CACHE_FLUSH_O), .CACHE_RESTART_O(CACHE_RESTART_O),
        .MEM_REQ_VALID_O(MEM_REQ_VALID_O), .MEM_REQ_READY_I(MEM_REQ_READY_I),
        .MEM_REQ_O(MEM_REQ_O), .MEM_RVALID_I(MEM_RVALID_I), .MEM_RDATA_I(MEM_RDATA_I));

    hiac_mem_model mem (.clk_i(CLK_I), .stall_i(stall), .valid_i(MEM_REQ_VALID_O),
        .ready_o(MEM_REQ_READY_I), .req_i(MEM_REQ_O), .rvalid_o(MEM_RVALID_I),
        .rdata_o(MEM_RDATA_I));

    initial begin
        CLK_I = 1'b0;
        forever #12.5 CLK_I = ~CLK_I;
    end

    always @(posedge CLK_I) begin
        if (CACHE_RESTART_O === 1'b1) pulses++;
    end

    function automatic logic [15:0] word(input logic [31:0] x);
        return x[19:4] ^ 16'h5A3C;
    endfunction : word

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic cpu(input logic we, input logic [31:0] ad, input logic [15:0] wd);
        @(negedge CLK_I);
        CPU_SEL_I = 1'b1;
        CPU_WE_I = we;
        CPU_ADDR_I = ad;
        CPU_WDATA_I = wd;
        @(negedge CLK_I);
        CPU_SEL_I = 1'b0;
        @(negedge CLK_I);
        rd = CPU_RDATA_O;
    endtask : cpu

    task automatic host(input logic [1:0] sel, input logic [1:0] ben, input logic wr,
                        input logic [15:0] wd);
        int k;
        k = 0;
        while (HOST_RDY_O !== 1'b1 && k < 400) begin
            @(negedge CLK_I);
            k++;
        end
        if (k == 400) check("host ready", 0, 1);
        @(negedge CLK_I);
        HOST_CS_I = 1'b1;
        HOST_SEL_I = sel;
        HOST_BEN_N_I = ben;
        HOST_DATA_I = wd;
        HOST_WR_N_I = !wr;
        HOST_RD_N_I = wr;
        repeat (8) @(negedge CLK_I);
        rd = HOST_DATA_O;
        check("data enable", HOST_DATA_OE_O, 32'(!wr));
        HOST_WR_N_I = 1'b1;
        HOST_RD_N_I = 1'b1;
        @(negedge CLK_I);
        HOST_CS_I = 1'b0;
        repeat (5) @(negedge CLK_I);
    endtask : host

    task automatic idle();
        int k;
        k = 0;
        repeat (12) @(negedge CLK_I);
        while ((MEM_REQ_VALID_O !== 1'b0 || HOST_RDY_O !== 1'b1) && k < 400) begin
            @(negedge CLK_I);
            k++;
        end
        if (k == 400) check("idle", 0, 1);
    endtask : idle

    initial begin
        #1500000;
        bad_count++;
        give_verdict();
    end

    initial begin
        RSTN_I = 1'b0;
        HOST_CS_I = 1'b1;
        HOST_RD_N_I = 1'b1;
        HOST_WR_N_I = 1'b1;
        HOST_SEL_I = 2'h0;
        HOST_BEN_N_I = 2'h0;
        HOST_DATA_I = 16'h0000;
        CPU_SEL_I = 1'b0;
        CPU_WE_I = 1'b0;
        CPU_ADDR_I = 32'h00000000;
        CPU_WDATA_I = 16'h0000;
        NMI_TAKEN_I = 1'b0;
        CACHE_DISABLE_I = 1'b0;
        stall = 1'b0;
        void'($urandom(89));
        repeat (16) @(negedge CLK_I);
        RSTN_I = 1'b1;
        repeat (3) @(negedge CLK_I);
        HOST_CS_I = 1'b0;
        check("halt", HALT_O, 1);
        cpu(0, HIAC_CTL_ADDR, 16'h0000);
        check("ctl reset", rd, 16'h8000);
        cpu(1, HIAC_CTL_ADDR, 16'hFFFF);
        cpu(0, HIAC_CTL_ADDR, 16'h0000);
        check("ctl mask", rd, 16'hFB00);
        check("nmi halted", NMI_REQ_O, 0);
        check("flush", CACHE_FLUSH_O, 1);
        for (int i = 0; i < 2; i++) begin
            CACHE_DISABLE_I = i[0];
            cpu(1, HIAC_CTL_ADDR, 16'h4000);
            r0 = pulses;
            cpu(1, HIAC_CTL_ADDR, 16'h0000);
            repeat (4) @(negedge CLK_I);
            check("restart", pulses - r0, 32'(i == 0));
        end
        host(HIAC_SEL_CTL, 2'b00, 1, 16'h03FF);
        check("nmi req", NMI_REQ_O, 1);
        check("nmi mode", NMI_MODE_O, 1);
        NMI_TAKEN_I = 1'b1;
        @(negedge CLK_I);
        NMI_TAKEN_I = 1'b0;
        cpu(0, HIAC_CTL_ADDR, 16'h0000);
        check("nmi clear", NMI_REQ_O, 0);
        check("ctl host", rd, 16'h0200);
        host(HIAC_SEL_CTL, 2'b00, 0, 16'h0000);
        check("host ctl read", rd, 16'h0200);
        r0 = mem.reqs;
        cpu(1, HIAC_PTR_HI_ADDR, 16'h1234);
        cpu(1, HIAC_PTR_LO_ADDR, 16'h567F);
        cpu(0, HIAC_PTR_LO_ADDR, 16'h0000);
        repeat (10) @(negedge CLK_I);
        check("cpu ptr", mem.reqs - r0, 0);
        check("ptr low", rd, 16'h5670);
        for (int inc = 1; inc >= 0; inc--) begin
            host(HIAC_SEL_CTL, 2'b00, 1, inc ? 16'h1000 : 16'h0000);
            hi = 16'($urandom());
            lo = 16'($urandom());
            a = {hi, lo} & HIAC_WORD_MASK;
            r0 = mem.reqs;
            host(HIAC_SEL_PTR_HI, 2'b10, 1, hi);
            host(HIAC_SEL_PTR_LO, 2'b00, 1, lo);
            idle();
            check("no trigger", mem.reqs - r0, 0);
            host(HIAC_SEL_PTR_HI, 2'b00, 1, hi);
            idle();
            check("fetch addr", mem.last.addr, a);
            check("fetch kind", mem.last.we, 0);
            for (int j = 0; j < 4; j++) begin
                host(HIAC_SEL_DATA, 2'b00, 0, 16'h0000);
                check("data", rd, word(a + (inc ? 32'(j) * 16 : 0)));
                idle();
            end
            check("refetch", mem.reqs - r0, 5);
            cpu(0, HIAC_PTR_LO_ADDR, 16'h0000);
            check("ptr step", rd, a[15:0] + (inc ? 16'h0040 : 16'h0000));
        end
        host(HIAC_SEL_CTL, 2'b00, 1, 16'h2800);
        host(HIAC_SEL_PTR_HI, 2'b00, 1, 16'hFFFF);
        host(HIAC_SEL_PTR_LO, 2'b00, 1, 16'hFFF5);
        idle();
        check("order one fetch", mem.last.addr, 32'hFFFFFFF0);
        r0 = mem.reqs;
        d = 16'($urandom());
        host(HIAC_SEL_DATA, 2'b01, 1, d);
        idle();
        check("upper byte", mem.reqs - r0, 0);
        host(HIAC_SEL_DATA, 2'b10, 1, d);
        idle();
        check("write data", mem.last.wdata, d);
        check("write addr", mem.last.addr, 32'hFFFFFFF0);
        cpu(0, HIAC_PTR_HI_ADDR, 16'h0000);
        check("wrap", rd, 16'h0000);
        host(HIAC_SEL_CTL, 2'b00, 1, 16'h0800);
        cpu(1, HIAC_PTR_HI_ADDR, 16'h0040);
        cpu(1, HIAC_PTR_LO_ADDR, 16'h0000);
        idle();
        stall = 1'b1;
        n = 0;
        while (n < 12 && HOST_RDY_O === 1'b1) begin
            d = 16'($urandom());
            host(HIAC_SEL_DATA, 2'b00, 1, d);
            n++;
        end
        check("fifo full", 32'(n >= 8 && n <= 9), 1);
        stall = 1'b0;
        idle();
        check("drain addr", mem.last.addr, 32'h00400000 + 32'(n - 1) * 16);
        check("drain data", mem.last.wdata, d);
        RSTN_I = 1'b0;
        repeat (16) @(negedge CLK_I);
        RSTN_I = 1'b1;
        repeat (3) @(negedge CLK_I);
        check("halt low", HALT_O, 0);
        cpu(0, HIAC_PTR_HI_ADDR, 16'h0000);
        check("ptr after reset", rd, 16'h0000);
        give_verdict();
    end
endmodule : host_indirect_access_control_bench

//--- hdl/hiac_pkg.sv
package hiac_pkg;

    // Register byte addresses on the processor side
    localparam logic [31:0] HIAC_DATA_ADDR = 32'hC00000C0;
    localparam logic [31:0] HIAC_PTR_LO_ADDR = 32'hC00000D0;
    localparam logic [31:0] HIAC_PTR_HI_ADDR = 32'hC00000E0;
    localparam logic [31:0] HIAC_CTL_ADDR = 32'hC0000100;

    // Host register select codes
    localparam logic [1:0] HIAC_SEL_PTR_LO = 2'h0;
    localparam logic [1:0] HIAC_SEL_PTR_HI = 2'h1;
    localparam logic [1:0] HIAC_SEL_DATA = 2'h2;
    localparam logic [1:0] HIAC_SEL_CTL = 2'h3;

    // Control field positions
    localparam int HIAC_NMI_BIT = 8;
    localparam int HIAC_UNMASKABLE_CONTEXT_MODE_BIT = 9;
    localparam int HIAC_WRITE_AUTO_INCREMENT_BIT = 11;
    localparam int HIAC_READ_AUTO_INCREMENT_BIT = 12;
    localparam int HIAC_LBL_BIT = 13;
    localparam int HIAC_CF_BIT = 14;
    localparam int HIAC_HLT_BIT = 15;

    // Writable control bits and reset values
    localparam logic [15:0] HIAC_CTL_WMASK = 16'hFB00;
    localparam logic [15:0] HIAC_CTL_RESET = 16'h0000;
    localparam logic [15:0] HIAC_PTR_RESET = 16'h0000;
    localparam logic [15:0] HIAC_DATA_RESET = 16'h0000;

    // Pointer step and word alignment
    localparam logic [31:0] HIAC_PTR_STEP = 32'h00000010;
    localparam logic [31:0] HIAC_WORD_MASK = 32'hFFFFFFF0;

    // Request buffer shape
    localparam int HIAC_FIFO_DEPTH = 8;

    typedef struct packed {
        logic cs;
        logic rd_n;
        logic wr_n;
        logic [1:0] sel;
        logic [1:0] ben_n;
        logic [15:0] data;
    } hiac_host_pins_t;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [15:0] wdata;
    } hiac_mem_req_t;

endpackage : hiac_pkg

//--- hdl/hiac_top.sv
`timescale 1ns/1ps

module hiac_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rp_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) mem_q[wp_q] <= in_data_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
            if (pop) rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : hiac_fifo

// What this block does
// - Pointer is upper half over lower half
// - Four pointer LSBs always forced zero
// - Pointer increment wraps to zero
// - Processor pointer writes start no read
// - Control bits shared by host and processor
// - Host write sets unmaskable interrupt request
// - Core takes request at next boundary
// - Taking interrupt clears request bit
// - Interrupt leaves refresh and registers alone
// - Mode bit selects save or discard context
// - Interrupt does not reset I/O registers
// - Flush bit clears present flags, disables cache
// - Flush falling restarts cache from reset state while CACHE_DISABLE_I is low
// - Order zero triggers on upper byte
// - Order one triggers on lower byte
// - Each cycle moves one 16-bit word
// - Read auto-increment bit steers pre-read step
// - Write auto-increment bit steers post-write step
// - Read step 16 first; every trigger-byte read refetches
// - Write then step 16; every trigger-byte write stores
// - Halt stops core and blocks interrupts
// - Halt bit follows chip select at reset
module hiac_top
    import hiac_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // Host pins
    input wire logic HOST_CS_I,
    input wire logic HOST_RD_N_I,
    input wire logic HOST_WR_N_I,
    input wire logic [1:0] HOST_SEL_I,
    input wire logic [1:0] HOST_BEN_N_I,
    input wire logic [15:0] HOST_DATA_I,
    output logic [15:0] HOST_DATA_O,
    output logic HOST_DATA_OE_O,
    output logic HOST_RDY_O,
    // On-chip processor register port
    input wire logic CPU_SEL_I,
    input wire logic CPU_WE_I,
    input wire logic [31:0] CPU_ADDR_I,
    input wire logic [15:0] CPU_WDATA_I,
    output logic [15:0] CPU_RDATA_O,
    // Core control
    input wire logic NMI_TAKEN_I,
    input wire logic CACHE_DISABLE_I,
    output logic NMI_REQ_O,
    output logic NMI_MODE_O,
    output logic HALT_O,
    output logic CACHE_FLUSH_O,
    output logic CACHE_RESTART_O,
    // Local memory
    output logic MEM_REQ_VALID_O,
    input wire logic MEM_REQ_READY_I,
    output hiac_mem_req_t MEM_REQ_O,
    input wire logic MEM_RVALID_I,
    input wire logic [15:0] MEM_RDATA_I
);
    hiac_host_pins_t s1_q, s2_q, s3_q, pins_q, pins_raw;
    logic act, act_prev_q, host_start, upper, lower, byte_order_select, trig_data, trig_ptr;
    logic host_wr, host_rd, strap_q, cf_prev_q, req_v_q, rd_pend_q, fifo_rdy;
    logic cpu_wr_lo, cpu_wr_hi, cpu_wr_ctl, cpu_wr_data, host_nmi_set;
    logic [15:0] ctl_q, ctl_d, hwdata, ptr_lo_q, ptr_hi_q, data_q;
    logic [15:0] ptr_lo_d, ptr_hi_d, data_d;
    logic [31:0] ptr, ptr_next, ptr_inc;
    hiac_mem_req_t req_q, req_d;
    logic req_set;

    // Host pin synchroniser
    assign pins_raw = '{cs: HOST_CS_I, rd_n: HOST_RD_N_I, wr_n: HOST_WR_N_I,
                        sel: HOST_SEL_I, ben_n: HOST_BEN_N_I, data: HOST_DATA_I};
    always_ff @(posedge CLK_I) begin
        s1_q <= pins_raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            pins_q <= '{cs: 1'b0, rd_n: 1'b1, wr_n: 1'b1, sel: 2'h0, ben_n: 2'h3,
                        data: 16'h0000};
            act_prev_q <= 1'b0;
        end else begin
            if (s2_q == s3_q) begin
                pins_q <= s3_q;
            end
            act_prev_q <= act;
        end
    end
    // Host access decode
    assign act = pins_q.cs && (!pins_q.rd_n || !pins_q.wr_n);
    assign host_start = act && !act_prev_q;
    assign host_wr = host_start && !pins_q.wr_n;
    assign host_rd = host_start && pins_q.rd_n == 1'b0 && pins_q.wr_n;
    assign upper = !pins_q.ben_n[1];
    assign lower = !pins_q.ben_n[0];
    assign byte_order_select = ctl_q[HIAC_LBL_BIT];
    assign trig_data = byte_order_select ? lower : upper;
    assign trig_ptr = host_wr && (byte_order_select ? (pins_q.sel == HIAC_SEL_PTR_LO && lower)
                                      : (pins_q.sel == HIAC_SEL_PTR_HI && upper));
    function automatic logic [15:0] hiac_merge(input logic [15:0] old,
                                               input logic [15:0] nw,
                                               input logic [1:0] ben_n);
        hiac_merge = {ben_n[1] ? old[15:8] : nw[15:8], ben_n[0] ? old[7:0] : nw[7:0]};
    endfunction : hiac_merge
    // Processor register decode
    assign cpu_wr_lo = CPU_SEL_I && CPU_WE_I && CPU_ADDR_I == HIAC_PTR_LO_ADDR;
    assign cpu_wr_hi = CPU_SEL_I && CPU_WE_I && CPU_ADDR_I == HIAC_PTR_HI_ADDR;
    assign cpu_wr_ctl = CPU_SEL_I && CPU_WE_I && CPU_ADDR_I == HIAC_CTL_ADDR;
    assign cpu_wr_data = CPU_SEL_I && CPU_WE_I && CPU_ADDR_I == HIAC_DATA_ADDR;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            CPU_RDATA_O <= 16'h0000;
        end else if (CPU_SEL_I && !CPU_WE_I) begin
            case (CPU_ADDR_I)
                HIAC_DATA_ADDR: CPU_RDATA_O <= data_q;
                HIAC_PTR_LO_ADDR: CPU_RDATA_O <= ptr_lo_q;
                HIAC_PTR_HI_ADDR: CPU_RDATA_O <= ptr_hi_q;
                HIAC_CTL_ADDR: CPU_RDATA_O <= ctl_q;
                default: CPU_RDATA_O <= 16'h0000;
            endcase
        end
    end
    // Control register, shared by both writers
    assign hwdata = hiac_merge(ctl_q, pins_q.data, pins_q.ben_n);
    assign host_nmi_set = host_wr && pins_q.sel == HIAC_SEL_CTL && upper
                          && pins_q.data[HIAC_NMI_BIT];
    always_comb begin
        ctl_d = ctl_q;
        if (NMI_TAKEN_I) ctl_d[HIAC_NMI_BIT] = 1'b0;
        if (host_wr && pins_q.sel == HIAC_SEL_CTL)
            ctl_d = (ctl_d & ~HIAC_CTL_WMASK) | (hwdata & HIAC_CTL_WMASK);
        if (cpu_wr_ctl)
            ctl_d = (ctl_d & ~HIAC_CTL_WMASK) | (CPU_WDATA_I & HIAC_CTL_WMASK);
        if (host_nmi_set) ctl_d[HIAC_NMI_BIT] = 1'b1;
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ctl_q <= HIAC_CTL_RESET;
            strap_q <= 1'b1;
            cf_prev_q <= 1'b0;
        end else begin
            strap_q <= 1'b0;
            cf_prev_q <= ctl_q[HIAC_CF_BIT];
            ctl_q <= ctl_d;
            if (strap_q) ctl_q[HIAC_HLT_BIT] <= s3_q.cs;
        end
    end
    // Core control outputs
    assign HALT_O = ctl_q[HIAC_HLT_BIT];
    assign NMI_REQ_O = ctl_q[HIAC_NMI_BIT] && !ctl_q[HIAC_HLT_BIT];
    assign NMI_MODE_O = ctl_q[HIAC_UNMASKABLE_CONTEXT_MODE_BIT];
    assign CACHE_FLUSH_O = ctl_q[HIAC_CF_BIT];
    assign CACHE_RESTART_O = cf_prev_q && !ctl_q[HIAC_CF_BIT] && !CACHE_DISABLE_I;
    // Pointer and data buffer
    assign ptr = {ptr_hi_q, ptr_lo_q} & HIAC_WORD_MASK;
    assign ptr_inc = ptr + HIAC_PTR_STEP;

    always_comb begin
        ptr_lo_d = ptr_lo_q;
        ptr_hi_d = ptr_hi_q;
        data_d = data_q;
        req_set = 1'b0;
        req_d = req_q;
        if (cpu_wr_lo) ptr_lo_d = CPU_WDATA_I & HIAC_WORD_MASK[15:0];
        if (cpu_wr_hi) ptr_hi_d = CPU_WDATA_I;
        if (cpu_wr_data) data_d = CPU_WDATA_I;
        if (host_wr && pins_q.sel == HIAC_SEL_PTR_LO) begin
            ptr_lo_d = hiac_merge(ptr_lo_q, pins_q.data, pins_q.ben_n) & HIAC_WORD_MASK[15:0];
        end
        if (host_wr && pins_q.sel == HIAC_SEL_PTR_HI) begin
            ptr_hi_d = hiac_merge(ptr_hi_q, pins_q.data, pins_q.ben_n);
        end
        ptr_next = {ptr_hi_d, ptr_lo_d} & HIAC_WORD_MASK;
        if (trig_ptr) begin
            req_set = 1'b1;
            req_d = '{we: 1'b0, addr: ptr_next, wdata: 16'h0000};
        end
        if (host_wr && pins_q.sel == HIAC_SEL_DATA) begin
            data_d = hiac_merge(data_q, pins_q.data, pins_q.ben_n);
            if (trig_data) begin
                req_set = 1'b1;
                req_d = '{we: 1'b1, addr: ptr, wdata: data_d};
                if (ctl_q[HIAC_WRITE_AUTO_INCREMENT_BIT]) begin
                    {ptr_hi_d, ptr_lo_d} = ptr_inc;
                end
            end
        end
        if (host_rd && pins_q.sel == HIAC_SEL_DATA && trig_data) begin
            req_set = 1'b1;
            req_d = '{we: 1'b0, addr: ctl_q[HIAC_READ_AUTO_INCREMENT_BIT] ? ptr_inc : ptr,
                      wdata: 16'h0000};
            if (ctl_q[HIAC_READ_AUTO_INCREMENT_BIT]) begin
                {ptr_hi_d, ptr_lo_d} = ptr_inc;
            end
        end
        if (MEM_RVALID_I && rd_pend_q) data_d = MEM_RDATA_I;
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ptr_lo_q <= HIAC_PTR_RESET;
            ptr_hi_q <= HIAC_PTR_RESET;
            data_q <= HIAC_DATA_RESET;
        end else begin
            ptr_lo_q <= ptr_lo_d;
            ptr_hi_q <= ptr_hi_d;
            data_q <= data_d;
        end
    end
    // Request hand-off into the buffer
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            req_v_q <= 1'b0;
            req_q <= '0;
            rd_pend_q <= 1'b0;
        end else begin
            if (req_set) begin
                req_v_q <= 1'b1;
                req_q <= req_d;
            end else if (fifo_rdy) begin
                req_v_q <= 1'b0;
            end
            if (req_set && !req_d.we) begin
                rd_pend_q <= 1'b1;
            end else if (MEM_RVALID_I) begin
                rd_pend_q <= 1'b0;
            end
        end
    end
    hiac_fifo #(
        .WIDTH($bits(hiac_mem_req_t)),
        .DEPTH(HIAC_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .in_valid_i(req_v_q),
        .in_ready_o(fifo_rdy),
        .in_data_i(req_q),
        .out_valid_o(MEM_REQ_VALID_O),
        .out_ready_i(MEM_REQ_READY_I),
        .out_data_o(MEM_REQ_O)
    );
    assign HOST_RDY_O = fifo_rdy && !req_v_q && !rd_pend_q;
    // Host read return
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            HOST_DATA_O <= 16'h0000;
            HOST_DATA_OE_O <= 1'b0;
        end else begin
            HOST_DATA_OE_O <= pins_q.cs && !pins_q.rd_n && pins_q.wr_n;
            if (host_rd) begin
                case (pins_q.sel)
                    HIAC_SEL_PTR_LO: HOST_DATA_O <= ptr_lo_q;
                    HIAC_SEL_PTR_HI: HOST_DATA_O <= ptr_hi_q;
                    HIAC_SEL_DATA: HOST_DATA_O <= data_q;
                    HIAC_SEL_CTL: HOST_DATA_O <= ctl_q & HIAC_CTL_WMASK;
                    default: HOST_DATA_O <= 16'h0000;
                endcase
            end
        end
    end
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    property p_align;
        req_v_q |-> req_q.addr[3:0] == 4'h0;
    endproperty
    a_align: assert property (p_align) else $error("request address not word aligned");
    property p_wrap;
        host_wr && pins_q.sel == HIAC_SEL_DATA && trig_data && ctl_q[HIAC_WRITE_AUTO_INCREMENT_BIT]
            && ptr == HIAC_WORD_MASK && !cpu_wr_lo && !cpu_wr_hi |=> ptr == 32'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap to zero");
    property p_cpu_no_read;
        (cpu_wr_lo || cpu_wr_hi) && !host_start && !req_v_q |=> !req_v_q;
    endproperty
    a_cpu_no_read: assert property (p_cpu_no_read) else $error("processor write fetched");
    property p_nmi_clear;
        NMI_TAKEN_I && !host_nmi_set ##1 !host_nmi_set |-> !ctl_q[HIAC_NMI_BIT];
    endproperty
    a_nmi_clear: assert property (p_nmi_clear) else $error("request bit not cleared");
    property p_halt_block;
        HALT_O |-> !NMI_REQ_O;
    endproperty
    a_halt_block: assert property (p_halt_block) else $error("interrupt while halted");
    property p_restart;
        $fell(ctl_q[HIAC_CF_BIT]) && !CACHE_DISABLE_I |-> CACHE_RESTART_O ##1 !CACHE_RESTART_O;
    endproperty
    a_restart: assert property (p_restart) else $error("cache restart pulse wrong");
    property p_rd_inc;
        host_rd && pins_q.sel == HIAC_SEL_DATA && trig_data && ctl_q[HIAC_READ_AUTO_INCREMENT_BIT]
            |=> req_v_q && !req_q.we && req_q.addr == $past(ptr) + HIAC_PTR_STEP;
    endproperty
    a_rd_inc: assert property (p_rd_inc) else $error("read not preceded by step");
    property p_wr_addr;
        host_wr && pins_q.sel == HIAC_SEL_DATA && trig_data
            |=> req_v_q && req_q.we && req_q.addr == $past(ptr);
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write used wrong address");
    property p_reserved;
        (ctl_q & ~HIAC_CTL_WMASK) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved control bit set");
    c_rd_fetch: cover property (host_rd && pins_q.sel == HIAC_SEL_DATA ##[1:20] MEM_RVALID_I);
    c_wr_store: cover property (host_wr && pins_q.sel == HIAC_SEL_DATA && trig_data);
    c_nmi: cover property (host_nmi_set ##[1:20] NMI_TAKEN_I);
    c_fifo_full: cover property (!fifo_rdy);
endmodule : hiac_top
